//--- rtl/dcw_cfg.svh
// register offsets, field positions, widths and timing counts
// assumes inclusion by bare name from the package and design files
`ifndef DCW_CFG_SVH
`define DCW_CFG_SVH
`define DCW_OFS_GEN_CTRL 32'h3FF48898
`define DCW_OFS_OUT_CTRL 32'h3FF4889C
`define DCW_OFS_CODE 32'h3FF488A0
`define DCW_OFS_STATUS 32'h3FF488A4
`define DCW_CODE_W 8
`define DCW_STEP_W 16
`define DCW_GEN_STEP_LSB 0
`define DCW_GEN_DMA_BIT 16
`define DCW_GEN_SIM_BIT 17
`define DCW_GEN_FSM_BIT 18
`define DCW_GEN_LP_BIT 19
`define DCW_OUT_DC0_LSB 0
`define DCW_OUT_DC1_LSB 8
`define DCW_OUT_SC0_LSB 16
`define DCW_OUT_SC1_LSB 18
`define DCW_OUT_PH0_LSB 20
`define DCW_OUT_PH1_LSB 22
`define DCW_OUT_CW0_BIT 24
`define DCW_OUT_CW1_BIT 25
`define DCW_OUT_PU0_BIT 26
`define DCW_OUT_PU1_BIT 27
`define DCW_CODE_C1_LSB 8
`define DCW_GEN_CLK_HZ 8000000
`define DCW_SYS_CLK_HZ 100000000
`define DCW_GEN_DIV ((`DCW_SYS_CLK_HZ + `DCW_GEN_CLK_HZ - 1) / `DCW_GEN_CLK_HZ)
`endif

//--- rtl/dcw_dac_ctrl.sv
// dual 8-bit dac digital control with cosine generator and dma path
// assumes avalon-mm master on i_clk; audio pins from another domain
// Notes on behaviour
// - two channels with 8-bit codes, each with its own settings.
// - channels update on their own or together on a shared strobe.
// - each code comes from the cosine generator, software or dma.
// - a channel converts only while its power-up bit is set.
// - conversion start comes from software or the adc sequencer.
// - the low-power coprocessor may drive every control itself.
// - a 16-bit step written by software sets generator frequency.
// - the generator advances on a tick every 13 cycles, about 7.7 MHz.
// - a 2-bit scale multiplies amplitude by 1, 1/2, 1/4 or 1/8.
// - an 8-bit offset is added and the sum saturates.
// - a 2-bit phase shifts the wave by 0, 90, 180 or 270 degrees.
// - one dma stream feeds both channels, a byte of each word each.
// - dma select routes audio clock and data to the dac.
// - dma select acts on both channels together.
`timescale 1ns/1ns
`include "dcw_cfg.svh"
module dcw_dac_ctrl (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic [31:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_seq_start,
	input wire logic i_lp_en,
	input wire logic [31:0] i_lp_gen_ctrl,
	input wire logic [31:0] i_lp_out_ctrl,
	input wire logic [15:0] i_lp_code,
	input wire logic i_lp_start,
	input wire logic i_aud_clk,
	input wire logic i_aud_data,
	input wire logic i_aud_ws,
	output logic o_dma_ready,
	output logic [7:0] o_ch0_code,
	output logic [7:0] o_ch1_code,
	output logic o_ch0_power_up,
	output logic o_ch1_power_up,
	output logic o_ch0_convert,
	output logic o_ch1_convert,
	output logic o_dac_clk
);
	logic [31:0] gen_ff, nxt_gen, out_ff, nxt_out;
	logic [15:0] code_ff, nxt_code;
	logic start_ff, nxt_start;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [31:0] gen_eff, out_eff;
	logic [15:0] code_eff;
	logic [31:0] wmask;
	logic sel_gen, sel_out, sel_code, sel_stat;
	// audio synchronisers, three stages each
	logic [2:0] aclk_s_ff, adat_s_ff, aws_s_ff;
	logic aclk_ff, adat_ff, aws_ff;
	logic ws_edge_ff, nxt_ws_edge;
	logic nxt_aclk, nxt_adat, nxt_aws;
	logic [15:0] shr_ff, nxt_shr;
	logic [4:0] bit_ff, nxt_bit;
	logic word_vld;
	logic buf_rdy, buf_vld;
	logic [15:0] buf_data;
	logic [15:0] dma_ff, nxt_dma;
	logic [15:0] acc_ff, nxt_acc;
	logic [3:0] div_ff, nxt_div;
	logic tick;
	logic [7:0] cw0, cw1;
	dcw_pkg::dcw_wave_cfg_t wcfg0, wcfg1;
	logic [7:0] src0, src1;
	logic [7:0] ch0_ff, ch1_ff, nxt_ch0, nxt_ch1;
	logic cv0_ff, cv1_ff, nxt_cv0, nxt_cv1;
	logic dma_on, sim, go, dma_take;

	// low-power coprocessor takes over every control
	assign gen_eff = i_lp_en ? i_lp_gen_ctrl : gen_ff;
	assign out_eff = i_lp_en ? i_lp_out_ctrl : out_ff;
	assign code_eff = i_lp_en ? i_lp_code : code_ff;
	assign dma_on = gen_eff[`DCW_GEN_DMA_BIT];
	assign sim = gen_eff[`DCW_GEN_SIM_BIT];
	// a powered-down pair stalls the stream, so the buffer keeps words
	assign dma_take = dma_on && (out_eff[`DCW_OUT_PU0_BIT] ||
		out_eff[`DCW_OUT_PU1_BIT]);

	// bus decode and byte lanes
	always_comb begin
		sel_gen = i_avs_address == `DCW_OFS_GEN_CTRL;
		sel_out = i_avs_address == `DCW_OFS_OUT_CTRL;
		sel_code = i_avs_address == `DCW_OFS_CODE;
		sel_stat = i_avs_address == `DCW_OFS_STATUS;
		for (int b = 0; b < 4; b++)
			wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
	end

	// register writes; one wait cycle before each answer
	always_comb begin
		nxt_gen = gen_ff;
		nxt_out = out_ff;
		nxt_code = code_ff;
		nxt_start = 1'b0;
		nxt_ack = 1'b0;
		nxt_rdata = rdata_ff;
		if ((i_avs_read || i_avs_write) && !ack_ff) begin
			nxt_ack = 1'b1;
			if (i_avs_write) begin
				if (sel_gen)
					nxt_gen = (gen_ff & ~wmask) | (i_avs_writedata & wmask);
				if (sel_out)
					nxt_out = (out_ff & ~wmask) | (i_avs_writedata & wmask);
				if (sel_code)
					nxt_code = (code_ff & ~wmask[15:0]) |
						(i_avs_writedata[15:0] & wmask[15:0]);
				// writing status word fires a software start
				if (sel_stat && i_avs_byteenable[0])
					nxt_start = i_avs_writedata[0];
			end else begin
				// unmapped reads return zero
				nxt_rdata = 32'h0000_0000;
				if (sel_gen)
					nxt_rdata = gen_ff;
				if (sel_out)
					nxt_rdata = out_ff;
				if (sel_code)
					nxt_rdata = {16'h0000, code_ff};
				if (sel_stat)
					nxt_rdata = {acc_ff, ch1_ff, ch0_ff};
			end
		end
	end
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
	assign o_avs_readdata = rdata_ff;

	// bus registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gen_ff <= 32'h0000_0000;
			out_ff <= 32'h0000_0000;
			code_ff <= 16'h0000;
			start_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else if (i_ce) begin
			gen_ff <= nxt_gen;
			out_ff <= nxt_out;
			code_ff <= nxt_code;
			start_ff <= nxt_start;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	// audio pins pass three flops; change taken when last two agree
	always_comb begin
		nxt_aclk = (aclk_s_ff[1] == aclk_s_ff[2]) ? aclk_s_ff[2] : aclk_ff;
		nxt_adat = (adat_s_ff[1] == adat_s_ff[2]) ? adat_s_ff[2] : adat_ff;
		nxt_aws = (aws_s_ff[1] == aws_s_ff[2]) ? aws_s_ff[2] : aws_ff;
		word_vld = 1'b0;
		nxt_shr = shr_ff;
		nxt_bit = bit_ff;
		nxt_ws_edge = ws_edge_ff;
		// shift audio data on rising audio clock when dma routed
		// word select settles ahead of the clock edge, so it is judged
		// against its value at the previous edge, not the previous cycle
		if (dma_on && nxt_aclk && !aclk_ff) begin
			nxt_ws_edge = nxt_aws;
			if (nxt_aws != ws_edge_ff) begin
				nxt_bit = 5'd1;
				nxt_shr = {15'h0000, nxt_adat};
			end else if (bit_ff < 5'd16) begin
				nxt_shr = {shr_ff[14:0], nxt_adat};
				nxt_bit = 5'(bit_ff + 5'd1);
				word_vld = bit_ff == 5'd15;
			end
		end
	end

	// audio synchroniser and deserialiser registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			aclk_s_ff <= 3'h0;
			adat_s_ff <= 3'h0;
			aws_s_ff <= 3'h0;
			aclk_ff <= 1'b0;
			adat_ff <= 1'b0;
			aws_ff <= 1'b0;
			ws_edge_ff <= 1'b0;
			shr_ff <= 16'h0000;
			bit_ff <= 5'd0;
		end else if (i_ce) begin
			aclk_s_ff <= {aclk_s_ff[1:0], i_aud_clk};
			adat_s_ff <= {adat_s_ff[1:0], i_aud_data};
			aws_s_ff <= {aws_s_ff[1:0], i_aud_ws};
			aclk_ff <= nxt_aclk;
			adat_ff <= nxt_adat;
			aws_ff <= nxt_aws;
			ws_edge_ff <= nxt_ws_edge;
			shr_ff <= nxt_shr;
			bit_ff <= nxt_bit;
		end
	end

	// a stalled word waits here; its ready is reported to the dma side
	dcw_skid_buf #(.W(16)) u_buf (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_en(i_ce),
		.i_valid(word_vld),
		.o_ready(buf_rdy),
		.i_data(nxt_shr),
		.o_valid(buf_vld),
		.i_ready(dma_take),
		.o_data(buf_data)
	);
	assign o_dma_ready = buf_rdy;
	// dac clock follows the audio clock while dma is selected
	assign o_dac_clk = dma_on & aclk_ff;

	// generator tick, accumulator and dma word hold
	always_comb begin
		tick = div_ff == 4'(`DCW_GEN_DIV - 1); // about 8 MHz
		nxt_div = tick ? 4'd0 : 4'(div_ff + 4'd1);
		// phase accumulator steps by software value
		nxt_acc = tick ? 16'(acc_ff + gen_eff[`DCW_GEN_STEP_LSB +: 16]) :
			acc_ff;
		// upper byte to channel 1, lower to channel 0
		nxt_dma = (buf_vld && dma_take) ? buf_data : dma_ff;
	end

	// generator registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_ff <= 4'd0;
			acc_ff <= 16'h0000;
			dma_ff <= 16'h0000;
		end else if (i_ce) begin
			div_ff <= nxt_div;
			acc_ff <= nxt_acc;
			dma_ff <= nxt_dma;
		end
	end

	// per-channel wave settings
	assign wcfg0 = '{phase: out_eff[`DCW_OUT_PH0_LSB +: 2],
		scale: out_eff[`DCW_OUT_SC0_LSB +: 2],
		offset: out_eff[`DCW_OUT_DC0_LSB +: 8]};
	assign wcfg1 = '{phase: out_eff[`DCW_OUT_PH1_LSB +: 2],
		scale: out_eff[`DCW_OUT_SC1_LSB +: 2],
		offset: out_eff[`DCW_OUT_DC1_LSB +: 8]};

	dcw_wave_shaper u_wave0 (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_en(i_ce),
		.i_phase(acc_ff),
		.i_cfg(wcfg0),
		.o_code(cw0)
	);
	dcw_wave_shaper u_wave1 (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_en(i_ce),
		.i_phase(acc_ff),
		.i_cfg(wcfg1),
		.o_code(cw1)
	);

	// source choice and conversion gating
	always_comb begin
		// dma overrides both channels at once
		if (dma_on) begin
			src0 = dma_ff[7:0];
			src1 = dma_ff[15:8];
		end else begin
			src0 = out_eff[`DCW_OUT_CW0_BIT] ? cw0 : code_eff[7:0];
			src1 = out_eff[`DCW_OUT_CW1_BIT] ? cw1 :
				code_eff[`DCW_CODE_C1_LSB +: 8];
		end
		// start source: sequencer, coprocessor or software
		if (dma_on)
			go = 1'b1;
		else if (i_lp_en)
			go = i_lp_start;
		else if (gen_eff[`DCW_GEN_FSM_BIT])
			go = i_seq_start;
		else
			go = start_ff;
		nxt_ch0 = ch0_ff;
		nxt_ch1 = ch1_ff;
		nxt_cv0 = 1'b0;
		nxt_cv1 = 1'b0;
		// powered-down channel holds and never converts
		// simultaneous mode waits for a start; else each runs freely
		if (out_eff[`DCW_OUT_PU0_BIT] && (!sim || go)) begin
			nxt_ch0 = src0;
			nxt_cv0 = 1'b1;
		end
		if (out_eff[`DCW_OUT_PU1_BIT] && (!sim || go)) begin
			nxt_ch1 = src1;
			nxt_cv1 = 1'b1;
		end
	end

	// channel output registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ch0_ff <= 8'h00;
			ch1_ff <= 8'h00;
			cv0_ff <= 1'b0;
			cv1_ff <= 1'b0;
		end else if (i_ce) begin
			ch0_ff <= nxt_ch0;
			ch1_ff <= nxt_ch1;
			cv0_ff <= nxt_cv0;
			cv1_ff <= nxt_cv1;
		end
	end
	assign o_ch0_code = ch0_ff;
	assign o_ch1_code = ch1_ff;
	assign o_ch0_convert = cv0_ff;
	assign o_ch1_convert = cv1_ff;
	assign o_ch0_power_up = out_eff[`DCW_OUT_PU0_BIT];
	assign o_ch1_power_up = out_eff[`DCW_OUT_PU1_BIT];
endmodule : dcw_dac_ctrl

//--- rtl/dcw_pkg.sv
// types shared by the dual dac control design
// assumes dcw_cfg.svh is on the include path
`include "dcw_cfg.svh"
package dcw_pkg;
	typedef struct packed {
		logic [1:0] phase;
		logic [1:0] scale;
		logic [7:0] offset;
	} dcw_wave_cfg_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} dcw_sample_t;
	typedef enum logic [1:0] {
		DCW_SRC_SW,
		DCW_SRC_CW,
		DCW_SRC_DMA
	} dcw_src_t;
endpackage : dcw_pkg

//--- rtl/dcw_skid_buf.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock; pop and push may happen in one cycle
`timescale 1ns/1ns
module dcw_skid_buf #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_en,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	logic [W-1:0] mem_ff [0:1];
	logic [W-1:0] nxt_mem [0:1];
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic push;
	logic pop;

	assign o_ready = i_en && (cnt_ff != 2'd2);
	assign o_valid = cnt_ff != 2'd0;
	assign o_data = mem_ff[0];

	// shift-out storage, entry 0 is the head
	always_comb begin
		push = i_valid && o_ready;
		pop = o_valid && i_ready && i_en;
		nxt_mem[0] = mem_ff[0];
		nxt_mem[1] = mem_ff[1];
		nxt_cnt = cnt_ff;
		if (pop) begin
			nxt_mem[0] = mem_ff[1];
		end
		if (push) begin
			nxt_mem[2'(cnt_ff - 2'(pop)) == 2'd0 ? 0 : 1] = i_data;
		end
		nxt_cnt = 2'(cnt_ff + 2'(push) - 2'(pop));
	end

	// registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
			cnt_ff <= 2'd0;
		end else begin
			mem_ff[0] <= nxt_mem[0];
			mem_ff[1] <= nxt_mem[1];
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : dcw_skid_buf

//--- rtl/dcw_wave_shaper.sv
// one channel: phase, scale and saturating offset of the cosine wave
// assumes a 16-bit accumulator phase from the parent, same clock
`timescale 1ns/1ns
module dcw_wave_shaper (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_en,
	input wire logic [15:0] i_phase,
	input wire dcw_pkg::dcw_wave_cfg_t i_cfg,
	output logic [7:0] o_code
);
	logic [7:0] code_ff;
	logic [7:0] nxt_code;
	logic [15:0] ph;
	logic [5:0] idx;
	logic [6:0] mag;
	logic signed [8:0] wave;
	logic signed [8:0] scaled;
	logic signed [9:0] sum;

	// quarter-wave table, 16 steps of 127*cos; coarse to save area
	function automatic logic [6:0] qcos(input logic [5:0] k);
		case (k[5:2])
			4'h0: qcos = 7'h7F;
			4'h1: qcos = 7'h7E;
			4'h2: qcos = 7'h7D;
			4'h3: qcos = 7'h7A;
			4'h4: qcos = 7'h75;
			4'h5: qcos = 7'h70;
			4'h6: qcos = 7'h6A;
			4'h7: qcos = 7'h62;
			4'h8: qcos = 7'h5A;
			4'h9: qcos = 7'h51;
			4'hA: qcos = 7'h47;
			4'hB: qcos = 7'h3C;
			4'hC: qcos = 7'h31;
			4'hD: qcos = 7'h25;
			4'hE: qcos = 7'h19;
			default: qcos = 7'h0C;
		endcase
	endfunction : qcos

	// phase select adds quarter turns: cos or sine outputs
	always_comb begin
		ph = i_phase + {i_cfg.phase, 14'h0000};
		// odd quadrants read the table backwards at 64 - p, so an exact
		// quarter turn lands on zero instead of the last table step
		if (ph[14]) begin
			idx = 6'(~ph[13:8] + 6'h01);
			mag = (ph[13:8] == 6'h00) ? 7'h00 : qcos(idx);
		end else begin
			idx = ph[13:8];
			mag = qcos(idx);
		end
		wave = (ph[15] ^ ph[14]) ? -$signed({2'b00, mag}) :
			$signed({2'b00, mag});
		scaled = wave >>> i_cfg.scale; // x1, 1/2, 1/4, 1/8
		sum = 10'(scaled) + $signed({2'b00, i_cfg.offset});
		// clamp instead of wrap
		if (sum < 0)
			nxt_code = 8'h00;
		else if (sum > 10'sd255)
			nxt_code = 8'hFF;
		else
			nxt_code = sum[7:0];
	end

	// output register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			code_ff <= 8'h00;
		else if (i_en)
			code_ff <= nxt_code;
	end
	assign o_code = code_ff;
endmodule : dcw_wave_shaper

//--- test/dcw_aud_src.sv
// serial audio source standing in for the dma stream
// assumes the bench calls send_word; clock idles low between words
`timescale 1ns/1ns
module dcw_aud_src (
	output logic o_aud_clk,
	output logic o_aud_data,
	output logic o_aud_ws
);
	// idle levels before the first word
	initial begin
		o_aud_clk = 1'b0;
		o_aud_data = 1'b0;
		o_aud_ws = 1'b0;
	end
	// one word feeds both channels: low byte ch0, high byte ch1
	task automatic send_word(input logic [15:0] w);
		int i;
		o_aud_ws = ~o_aud_ws;
		for (i = 15; i >= 0; i--) begin
			o_aud_data = w[i];
			#55 o_aud_clk = 1'b1;
			#55 o_aud_clk = 1'b0;
		end
		// released line must not keep showing the last bit
		o_aud_data = ~w[0];
		#110;
	endtask : send_word
endmodule : dcw_aud_src

//--- test/dcw_dac_ctrl_props.sv
// concurrent checks on the dual dac control ports
// assumes a bind from the bench top; one clock, async low reset
`timescale 1ns/1ns
`include "dcw_cfg.svh"
module dcw_dac_ctrl_props (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [31:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_lp_en,
	input wire logic [31:0] i_lp_out_ctrl,
	input wire logic i_aud_clk,
	input wire logic [7:0] o_ch0_code,
	input wire logic [7:0] o_ch1_code,
	input wire logic o_ch0_power_up,
	input wire logic o_ch1_power_up,
	input wire logic o_ch0_convert,
	input wire logic o_ch1_convert,
	input wire logic o_dac_clk
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	logic [3:0] aud_low_ff;
	logic [3:0] nxt_aud_low;
	logic mapped;
	assign mapped = i_avs_address inside {`DCW_OFS_GEN_CTRL, `DCW_OFS_OUT_CTRL,
		`DCW_OFS_CODE, `DCW_OFS_STATUS};
	// cycles since the audio clock was last high; saturates, no wrap
	always_comb begin
		nxt_aud_low = aud_low_ff;
		if (i_aud_clk)
			nxt_aud_low = 4'h0;
		else if (aud_low_ff != 4'hF)
			nxt_aud_low = aud_low_ff + 4'h1;
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			aud_low_ff <= 4'hF;
		else
			aud_low_ff <= nxt_aud_low;
	end
	// bus steps: a pending request, then its acknowledge
	sequence s_bus_pend;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence s_bus_ack;
		!o_avs_waitrequest;
	endsequence
	a_bus_one_wait: assert property (s_bus_pend |=> s_bus_ack)
		else $error("bus request not acknowledged after one wait");
	a_unmapped_zero: assert property (
		i_avs_read && !o_avs_waitrequest && !mapped
		|-> o_avs_readdata == 32'h0)
		else $error("unmapped read returned data");
	a_power0_gate: assert property (
		!o_ch0_power_up && !$past(o_ch0_power_up)
		|-> !o_ch0_convert)
		else $error("channel 0 converts while powered down");
	a_power1_gate: assert property (
		!o_ch1_power_up && !$past(o_ch1_power_up)
		|-> !o_ch1_convert)
		else $error("channel 1 converts while powered down");
	a_code0_conv: assert property ($changed(o_ch0_code) |-> o_ch0_convert)
		else $error("channel 0 code moved without a conversion");
	a_code1_conv: assert property ($changed(o_ch1_code) |-> o_ch1_convert)
		else $error("channel 1 code moved without a conversion");
	a_lp_power: assert property (
		i_lp_en && $past(i_lp_en) && $stable(i_lp_out_ctrl)
		|-> o_ch0_power_up == i_lp_out_ctrl[`DCW_OUT_PU0_BIT]
		&& o_ch1_power_up == i_lp_out_ctrl[`DCW_OUT_PU1_BIT])
		else $error("coprocessor power control not followed");
	a_dac_clk_src: assert property (o_dac_clk |-> aud_low_ff < 4'hC)
		else $error("dac clock high without audio clock");
endmodule : dcw_dac_ctrl_props

//--- test/test_dual_dac_control_cw_gen.sv
// directed bench for the dual dac control over avalon-mm
// assumes the checker and audio source model are compiled first
`timescale 1ns/1ns
`include "dcw_cfg.svh"
module test_dual_dac_control_cw_gen;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_ce = 1'b1;
	logic [31:0] i_avs_address = 32'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'hF;
	logic i_seq_start = 1'b0;
	logic i_lp_en = 1'b0;
	logic [31:0] i_lp_gen_ctrl = 32'h0;
	logic [31:0] i_lp_out_ctrl = 32'h0;
	logic [15:0] i_lp_code = 16'h0;
	logic i_lp_start = 1'b0;
	logic i_aud_clk, i_aud_data, i_aud_ws, o_avs_waitrequest, o_dma_ready;
	logic [31:0] o_avs_readdata, r, r2;
	logic [15:0] d;
	// codes {ch1, ch0} for cos at 180 and 0 degrees, offset 80, per scale
	logic [15:0] wexp [4] = '{16'h01FF, 16'h40BF, 16'h609F, 16'h708F};
	logic [7:0] o_ch0_code, o_ch1_code;
	logic o_ch0_power_up, o_ch1_power_up, o_ch0_convert, o_ch1_convert;
	logic o_dac_clk;
	int fails = 0;
	int num_checks = 0;
	dcw_dac_ctrl dut (.i_clk, .i_nrst, .i_ce, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
		.o_avs_waitrequest, .i_seq_start, .i_lp_en, .i_lp_gen_ctrl,
		.i_lp_out_ctrl, .i_lp_code, .i_lp_start, .i_aud_clk, .i_aud_data,
		.i_aud_ws, .o_dma_ready, .o_ch0_code, .o_ch1_code, .o_ch0_power_up,
		.o_ch1_power_up, .o_ch0_convert, .o_ch1_convert, .o_dac_clk);
	dcw_aud_src src (.o_aud_clk(i_aud_clk), .o_aud_data(i_aud_data),
		.o_aud_ws(i_aud_ws));
	// 100 MHz clock
	always #5 i_clk = ~i_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// power flags and both codes in one word
	function automatic logic [31:0] st();
		return {14'h0, o_ch1_power_up, o_ch0_power_up, o_ch1_code, o_ch0_code};
	endfunction : st
	// both conversion strobes in one word
	function automatic logic [31:0] cv();
		return {30'h0, o_ch1_convert, o_ch0_convert};
	endfunction : cv
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= wd;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] x;
		bus(1'b1, a, wd, x);
	endtask : wr
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// hang guard, well beyond the directed sequence
	initial begin
		#300000;
		fails++;
		stop_test();
	end
	initial begin
		cyc(5);
		i_nrst <= 1'b1;
		check(st(), 32'h0);
		wr(`DCW_OFS_GEN_CTRL, 32'h0000_1234);
		bus(1'b0, `DCW_OFS_GEN_CTRL, 32'h0, r);
		check(r, 32'h0000_1234);
		wr(`DCW_OFS_OUT_CTRL, 32'h0A5A_A5A5);
		bus(1'b0, `DCW_OFS_OUT_CTRL, 32'h0, r);
		check(r, 32'h0A5A_A5A5);
		bus(1'b0, 32'h3FF4_88A8, 32'h0, r);
		check(r, 32'h0);
		wr(`DCW_OFS_GEN_CTRL, 32'h0);
		wr(`DCW_OFS_OUT_CTRL, 32'h0C00_0000);
		wr(`DCW_OFS_CODE, 32'h0000_3CC3);
		cyc(4);
		check(st(), 32'h0003_3CC3);
		check(cv(), 32'h3);
		// shared start: codes wait for the strobe
		wr(`DCW_OFS_GEN_CTRL, 32'h0002_0000);
		wr(`DCW_OFS_CODE, 32'h0000_1122);
		cyc(4);
		check(st(), 32'h0003_3CC3);
		check(cv(), 32'h0);
		wr(`DCW_OFS_STATUS, 32'h1);
		cyc(4);
		check(st(), 32'h0003_1122);
		wr(`DCW_OFS_GEN_CTRL, 32'h0006_0000);
		wr(`DCW_OFS_CODE, 32'h0000_3344);
		cyc(4);
		check(st(), 32'h0003_1122);
		i_seq_start <= 1'b1;
		@(posedge i_clk);
		i_seq_start <= 1'b0;
		cyc(4);
		check(st(), 32'h0003_3344);
		wr(`DCW_OFS_OUT_CTRL, 32'h0);
		cyc(2);
		check(st(), 32'h0000_3344);
		check(cv(), 32'h0);
		// second reset clears the accumulator before the wave tests
		i_nrst <= 1'b0;
		cyc(5);
		i_nrst <= 1'b1;
		wr(`DCW_OFS_OUT_CTRL, 32'h0F80_00FF);
		cyc(30);
		check(st(), 32'h0003_00FF);
		// quarter turns cross zero; 0 and 180 degrees show the scaling
		for (int s = 0; s < 4; s++) begin
			wr(`DCW_OFS_OUT_CTRL, {8'h0F, 4'hD, s[1:0], s[1:0], 16'h8080});
			cyc(30);
			check(st(), 32'h0003_8080);
			wr(`DCW_OFS_OUT_CTRL, {8'h0F, 4'h8, s[1:0], s[1:0], 16'h8080});
			cyc(30);
			check(st(), {16'h0003, wexp[s]});
		end
		// 263 cycles between the two samples: 20 or 21 ticks of 13
		wr(`DCW_OFS_GEN_CTRL, 32'h0000_0003);
		bus(1'b0, `DCW_OFS_STATUS, 32'h0, r);
		cyc(260);
		bus(1'b0, `DCW_OFS_STATUS, 32'h0, r2);
		d = r2[31:16] - r[31:16];
		check({31'h0, d == 16'd60 || d == 16'd63}, 32'h1);
		i_lp_out_ctrl <= 32'h0400_0000;
		i_lp_code <= 16'h00A5;
		i_lp_en <= 1'b1;
		cyc(6);
		check(st() & 32'h0003_00FF, 32'h0001_00A5);
		i_lp_en <= 1'b0;
		wr(`DCW_OFS_OUT_CTRL, 32'h0C00_0000);
		wr(`DCW_OFS_GEN_CTRL, 32'h0001_0000);
		src.send_word(16'hBEEF);
		cyc(10);
		check(st(), 32'h0003_BEEF);
		// stalled channels: two words fit, the third is refused
		wr(`DCW_OFS_OUT_CTRL, 32'h0);
		src.send_word(16'h0102);
		src.send_word(16'h0304);
		src.send_word(16'h0506);
		cyc(10);
		check({31'h0, o_dma_ready}, 32'h0);
		wr(`DCW_OFS_OUT_CTRL, 32'h0C00_0000);
		cyc(10);
		check({31'h0, o_dma_ready}, 32'h1);
		check(st(), 32'h0003_0304);
		wr(`DCW_OFS_GEN_CTRL, 32'h0);
		wr(`DCW_OFS_CODE, 32'h0000_5566);
		cyc(4);
		check(st(), 32'h0003_5566);
		check({31'h0, o_dac_clk}, 32'h0);
		stop_test();
	end
endmodule : test_dual_dac_control_cw_gen
bind dcw_dac_ctrl dcw_dac_ctrl_props u_props (.i_clk, .i_nrst, .i_avs_address,
	.i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_lp_en,
	.i_lp_out_ctrl, .i_aud_clk, .o_ch0_code, .o_ch1_code, .o_ch0_power_up,
	.o_ch1_power_up, .o_ch0_convert, .o_ch1_convert, .o_dac_clk);
